//--- hw/rsgd_pkg.sv
// Package of constants, types and helpers for the receive DMA
package rsgd_pkg;
    // Register byte offsets
    localparam logic [11:0] RSGD_OFS_BASE_LO = 12'h750;
    localparam logic [11:0] RSGD_OFS_BASE_HI = 12'h754;
    localparam logic [11:0] RSGD_OFS_LARGE = 12'h790;
    localparam logic [11:0] RSGD_OFS_SMALL = 12'h794;
    localparam logic [11:0] RSGD_OFS_CTRL = 12'h7A0;
    localparam logic [11:0] RSGD_OFS_STAT = 12'h7A4;
    // Reset values
    localparam logic [12:0] RSGD_SIZE_RST = 13'h0000;
    localparam logic [15:0] RSGD_BASE_RST = 16'h0000;
    localparam logic [5:0] RSGD_CTRL_RST = 6'h04;
    // Control field positions
    localparam int RSGD_CTRL_EN = 0;
    localparam int RSGD_CTRL_BURST = 1;
    localparam int RSGD_CTRL_THR_LSB = 2;
    localparam int RSGD_CTRL_MODE = 5;
    // Descriptor buffer status codes
    localparam logic [2:0] RSGD_BUFS_FIRST = 3'h1;
    localparam logic [2:0] RSGD_BUFS_MID = 3'h2;
    localparam logic [2:0] RSGD_BUFS_LAST = 3'h4;
    // Word step and timestamp prescale
    localparam logic [13:0] RSGD_WORD_BYTES = 14'h0004;
    localparam logic [3:0] RSGD_TS_DIV_LAST = 4'hF;
    // Per-channel buffer policy
    typedef enum logic [1:0] {
        POL_LARGE,
        POL_SMALL,
        POL_MIXED
    } rsgd_policy_type;
    // Engine states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_DATA,
        ST_WRITE,
        ST_DESC,
        ST_DONE
    } rsgd_state_type;
    // Absolute descriptor address: aligned base plus sixteen per index
    function automatic logic [31:0] rsgd_desc_addr(
        input logic [31:0] base,
        input logic [15:0] idx
    );
        return {base[31:4], 4'h0} + {12'h000, idx, 4'h0};
    endfunction : rsgd_desc_addr
endpackage : rsgd_pkg

//--- hw/rsgd_tstamp.sv
// Arrival timestamp: 24-bit count advancing every sixteen clocks
module rsgd_tstamp (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Timestamp value
    output logic [23:0] tstamp
);
    import rsgd_pkg::*;

    logic [3:0] div_r; // Prescaler
    logic [23:0] ts_r; // Free-running stamp, wraps

    // Prescale by sixteen, then advance the stamp
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_r <= 4'h0;
            ts_r <= 24'h000000;
        end else begin
            div_r <= div_r + 4'h1;
            if (div_r == RSGD_TS_DIV_LAST) begin
                ts_r <= ts_r + 24'h000001;
            end
        end
    end

    assign tstamp = ts_r;
endmodule : rsgd_tstamp

//--- hw/rsgd_regs.sv
// AHB-Lite register slave for the receive DMA
module rsgd_regs (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Register contents
    output logic [31:0] desc_base,
    output logic [12:0] large_size,
    output logic [12:0] small_size,
    output logic [5:0] ctrl,
    // Status
    input wire logic [15:0] done_count,
    input wire logic busy
);
    import rsgd_pkg::*;

    logic addr_ok; // Valid address phase
    logic wr_pend_r; // Write data phase pending
    logic [11:0] wr_ofs_r; // Offset of pending write
    logic [31:0] rdata_r; // Registered read data
    logic [15:0] base_lo_r, base_hi_r;
    logic [12:0] large_r, small_r;
    logic [5:0] ctrl_r;

    assign addr_ok = hsel && hready && htrans[1] && (hsize == 3'h2);

    // Read decode; unmapped and unused bits read zero
    function automatic logic [31:0] rd_mux(input logic [11:0] ofs);
        case (ofs)
            RSGD_OFS_BASE_LO: return {16'h0000, base_lo_r};
            RSGD_OFS_BASE_HI: return {16'h0000, base_hi_r};
            RSGD_OFS_LARGE: return {19'h00000, large_r};
            RSGD_OFS_SMALL: return {19'h00000, small_r};
            RSGD_OFS_CTRL: return {26'h0000000, ctrl_r};
            RSGD_OFS_STAT: return {15'h0000, busy, done_count};
            default: return 32'h00000000;
        endcase
    endfunction : rd_mux

    // Capture address phase of writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_ofs_r <= 12'h000;
        end else begin
            wr_pend_r <= addr_ok && hwrite;
            wr_ofs_r <= haddr[11:0];
        end
    end

    // Register writes in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            base_lo_r <= RSGD_BASE_RST;
            base_hi_r <= RSGD_BASE_RST;
            large_r <= RSGD_SIZE_RST;
            small_r <= RSGD_SIZE_RST;
            ctrl_r <= RSGD_CTRL_RST;
        end else if (wr_pend_r) begin
            case (wr_ofs_r)
                RSGD_OFS_BASE_LO: base_lo_r <= hwdata[15:0];
                RSGD_OFS_BASE_HI: base_hi_r <= hwdata[15:0];
                RSGD_OFS_LARGE: large_r <= hwdata[12:0];
                RSGD_OFS_SMALL: small_r <= hwdata[12:0];
                RSGD_OFS_CTRL: ctrl_r <= hwdata[5:0];
                default: ctrl_r <= ctrl_r;
            endcase
        end
    end

    // Read data registered at the end of the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_r <= 32'h00000000;
        end else if (addr_ok && !hwrite) begin
            rdata_r <= rd_mux(haddr[11:0]);
        end
    end

    assign hrdata = rdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign desc_base = {base_hi_r, base_lo_r};
    assign large_size = large_r;
    assign small_size = small_r;
    assign ctrl = ctrl_r;
endmodule : rsgd_regs

//--- hw/rsgd_top.sv
// Receive scatter/gather DMA engine with its register slave
module rsgd_top (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite register slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Receive FIFO data stream
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [31:0] rx_data,
    input wire logic [2:0] rx_bytes,
    input wire logic rx_eop,
    input wire logic [7:0] rx_chan,
    input wire rsgd_pkg::rsgd_policy_type rx_policy,
    // Free-queue descriptor source
    output logic fq_req,
    output logic fq_small,
    output logic fq_burst,
    input wire logic fq_valid,
    input wire logic [31:0] fq_buf_addr,
    input wire logic [15:0] fq_desc_idx,
    // Memory write master
    output logic mem_req,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    // Done-queue sink and host notify
    output logic dq_valid,
    output logic [15:0] dq_desc_idx,
    output logic [7:0] dq_chan,
    output logic dq_burst,
    input wire logic dq_ready,
    output logic done_pulse
);
    import rsgd_pkg::*;

    logic [31:0] desc_base; // Descriptor region base
    logic [12:0] large_size, small_size;
    logic [5:0] ctrl; // Enable, burst, threshold, mode
    logic [23:0] tstamp; // Arrival timestamp
    rsgd_state_type state_r, state_nxt;
    rsgd_policy_type policy_r; // Policy of current packet
    logic [31:0] cur_buf_r, nxt_buf_r; // Current and next buffer
    logic [15:0] cur_idx_r, nxt_idx_r; // Current and next index
    logic [15:0] head_idx_r; // First unreported descriptor
    logic [12:0] cnt_r; // Bytes in current buffer
    logic [7:0] chan_r; // Channel of current packet
    logic small_r; // Current or wanted buffer is small
    logic first_r; // Packet has no buffer yet
    logic cur_first_r; // Current buffer is first of packet
    logic eop_r; // Last word written ended packet
    logic last_r; // Descriptor in progress is last
    logic [1:0] dw_r; // Descriptor dword in progress
    logic [2:0] filled_r; // Buffers filled since last report
    logic [15:0] done_count_r; // Reports made, for polling
    logic mem_req_r;
    logic [31:0] mem_addr_r, mem_wdata_r;
    logic [12:0] buf_size; // Size of current buffer
    logic buf_full, start, take_word, fq_take, desc_enter;
    logic desc_step, desc_end, report, dq_take, switch_buf;
    logic last_sel; // Last flag for word being issued
    logic [1:0] dw_sel; // Dword index being issued
    logic [31:0] desc_word; // Descriptor dword being issued
    logic [2:0] bufs; // Buffer status code

    // Register slave
    rsgd_regs u_regs (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .desc_base(desc_base),
        .large_size(large_size),
        .small_size(small_size),
        .ctrl(ctrl),
        .done_count(done_count_r),
        .busy(state_r != ST_IDLE)
    );

    // Timestamp source
    rsgd_tstamp u_tstamp (
        .hclk(hclk),
        .hresetn(hresetn),
        .tstamp(tstamp)
    );

    // Buffer choice and fill check, 14-bit so no wrap
    assign buf_size = small_r ? small_size : large_size;
    assign buf_full = ({1'b0, cnt_r} + RSGD_WORD_BYTES) >
        {1'b0, buf_size};

    // Handshakes
    assign start = (state_r == ST_IDLE) && ctrl[RSGD_CTRL_EN] &&
        rx_valid;
    assign rx_ready = (state_r == ST_DATA) && !buf_full && !mem_req_r;
    assign take_word = rx_valid && rx_ready;
    assign fq_req = (state_r == ST_FETCH);
    assign fq_small = small_r;
    assign fq_burst = ctrl[RSGD_CTRL_BURST];
    assign dq_burst = ctrl[RSGD_CTRL_BURST];
    assign fq_take = fq_req && fq_valid;
    assign dq_valid = (state_r == ST_DONE);
    assign dq_take = dq_valid && dq_ready;
    assign done_pulse = dq_take;

    // Descriptor write sequencing
    assign desc_enter = (fq_take && !first_r) ||
        ((state_r == ST_WRITE) && mem_ack && eop_r);
    assign desc_step = (state_r == ST_DESC) && mem_ack && (dw_r != 2'h2);
    assign desc_end = (state_r == ST_DESC) && mem_ack && (dw_r == 2'h2);
    assign report = desc_end && (last_r || (ctrl[RSGD_CTRL_MODE] &&
        ((filled_r + 3'h1) == ctrl[RSGD_CTRL_THR_LSB +: 3])));
    assign switch_buf = ((desc_end && !report) || dq_take) && !last_r;
    assign dw_sel = desc_enter ? 2'h0 : dw_r + 2'h1;
    assign last_sel = desc_enter ? (state_r == ST_WRITE) : last_r;

    // Descriptor dword contents
    always_comb begin
        if (last_sel) begin
            bufs = RSGD_BUFS_LAST;
        end else if (cur_first_r) begin
            bufs = RSGD_BUFS_FIRST;
        end else begin
            bufs = RSGD_BUFS_MID;
        end
        case (dw_sel)
            2'h0: desc_word = cur_buf_r;
            2'h1: desc_word = {bufs, cnt_r,
                last_sel ? 16'h0000 : nxt_idx_r};
            default: desc_word = {tstamp, chan_r};
        endcase
    end

    // Next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: if (start) state_nxt = ST_FETCH;
            ST_FETCH: if (fq_take) state_nxt = first_r ? ST_DATA : ST_DESC;
            ST_DATA: begin
                if (take_word) begin
                    state_nxt = ST_WRITE;
                end else if (buf_full) begin
                    state_nxt = ST_FETCH;
                end
            end
            ST_WRITE: if (mem_ack) state_nxt = eop_r ? ST_DESC : ST_DATA;
            ST_DESC: begin
                if (desc_end) begin
                    if (report) begin
                        state_nxt = ST_DONE;
                    end else begin
                        state_nxt = last_r ? ST_IDLE : ST_DATA;
                    end
                end
            end
            ST_DONE: if (dq_take) state_nxt = last_r ? ST_IDLE : ST_DATA;
            default: state_nxt = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Packet context and buffer selection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            policy_r <= POL_LARGE;
            chan_r <= 8'h00;
            small_r <= 1'b0;
            first_r <= 1'b0;
        end else if (start) begin
            policy_r <= rx_policy;
            chan_r <= rx_chan;
            small_r <= (rx_policy != POL_LARGE);
            first_r <= 1'b1;
        end else begin
            if (fq_take) begin
                first_r <= 1'b0;
            end
            if ((state_r == ST_DATA) && !take_word && buf_full) begin
                small_r <= (policy_r == POL_SMALL);
            end
        end
    end

    // Buffer and descriptor pointers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_buf_r <= 32'h00000000;
            cur_idx_r <= 16'h0000;
            nxt_buf_r <= 32'h00000000;
            nxt_idx_r <= 16'h0000;
            cur_first_r <= 1'b0;
        end else if (fq_take && first_r) begin
            cur_buf_r <= fq_buf_addr;
            cur_idx_r <= fq_desc_idx;
            cur_first_r <= 1'b1;
        end else if (fq_take) begin
            nxt_buf_r <= fq_buf_addr;
            nxt_idx_r <= fq_desc_idx;
        end else if (switch_buf) begin
            cur_buf_r <= nxt_buf_r;
            cur_idx_r <= nxt_idx_r;
            cur_first_r <= 1'b0;
        end
    end

    // Byte count and end-of-packet flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= 13'h0000;
            eop_r <= 1'b0;
        end else if (start || switch_buf) begin
            cnt_r <= 13'h0000;
            eop_r <= 1'b0;
        end else if (take_word) begin
            cnt_r <= cnt_r + {10'h000, rx_bytes};
            eop_r <= rx_eop;
        end
    end

    // Descriptor dword counter and last flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dw_r <= 2'h0;
            last_r <= 1'b0;
        end else if (desc_enter || desc_step) begin
            dw_r <= dw_sel;
            last_r <= last_sel;
        end
    end

    // Done-queue reporting and progress counters
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            head_idx_r <= 16'h0000;
            filled_r <= 3'h0;
            done_count_r <= 16'h0000;
        end else begin
            if (fq_take && first_r) begin
                head_idx_r <= fq_desc_idx;
            end else if (dq_take && !last_r) begin
                head_idx_r <= nxt_idx_r;
            end
            if (start && filled_r == 3'h0) begin
                filled_r <= 3'h0;
            end else if (desc_end) begin
                filled_r <= report ? 3'h0 : filled_r + 3'h1;
            end
            if (dq_take) begin
                done_count_r <= done_count_r + 16'h0001;
            end
        end
    end

    // Memory write master: data words and descriptor dwords
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_req_r <= 1'b0;
            mem_addr_r <= 32'h00000000;
            mem_wdata_r <= 32'h00000000;
        end else if (take_word) begin
            mem_req_r <= 1'b1;
            mem_addr_r <= cur_buf_r + {19'h00000, cnt_r};
            mem_wdata_r <= rx_data;
        end else if (desc_enter || desc_step) begin
            mem_req_r <= 1'b1;
            mem_addr_r <= rsgd_desc_addr(desc_base, cur_idx_r) +
                {28'h0000000, dw_sel, 2'h0};
            mem_wdata_r <= desc_word;
        end else if (mem_ack) begin
            mem_req_r <= 1'b0;
        end
    end

    assign mem_req = mem_req_r;
    assign mem_addr = mem_addr_r;
    assign mem_wdata = mem_wdata_r;
    assign dq_desc_idx = head_idx_r;
    assign dq_chan = chan_r;

    // Checks
    chk_start_fetch: assert property (@(posedge hclk) disable iff (!hresetn)
        start |=> fq_req)
        else $error("request did not start a fetch");
    chk_fill_bound: assert property (@(posedge hclk) disable iff (!hresetn)
        take_word |=> ({1'b0, cnt_r} <= {1'b0, buf_size}))
        else $error("buffer overfilled");
    chk_mixed_large: assert property (@(posedge hclk) disable iff (!hresetn)
        fq_req && !first_r && policy_r == POL_MIXED |-> !fq_small)
        else $error("mixed policy fetched small later buffer");
    chk_data_addr: assert property (@(posedge hclk) disable iff (!hresetn)
        take_word |=> mem_req &&
        mem_addr == $past(cur_buf_r) + {19'h00000, $past(cnt_r)})
        else $error("data write address wrong");
    chk_desc_addr: assert property (@(posedge hclk) disable iff (!hresetn)
        state_r == ST_DESC && mem_req |-> mem_addr[31:4] ==
        desc_base[31:4] + {12'h000, cur_idx_r})
        else $error("descriptor address wrong");
    chk_last_status: assert property (@(posedge hclk) disable iff (!hresetn)
        state_r == ST_DESC && mem_req && dw_r == 2'h1 && last_r |->
        mem_wdata[31:29] == RSGD_BUFS_LAST)
        else $error("last descriptor not marked last");
    chk_chain_next: assert property (@(posedge hclk) disable iff (!hresetn)
        state_r == ST_DESC && mem_req && dw_r == 2'h1 && !last_r |->
        mem_wdata[15:0] == nxt_idx_r && mem_wdata[28:16] == cnt_r)
        else $error("chain link or count wrong");
    chk_report_count: assert property (@(posedge hclk) disable iff (!hresetn)
        dq_take |=> done_count_r == $past(done_count_r) + 16'h0001)
        else $error("done progress not counted");
endmodule : rsgd_top

//--- dv/rsgd_host_model.sv
// Host-side model: free-queue supplier, memory target, done-queue reader
module rsgd_host_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Free-queue source
    input wire logic fq_req,
    output logic fq_valid,
    output logic [31:0] fq_buf_addr,
    output logic [15:0] fq_desc_idx,
    // Memory write target and done-queue sink
    input wire logic mem_req,
    output logic mem_ack,
    input wire logic dq_valid,
    output logic dq_ready
);
    logic [15:0] k; // Entries handed out so far
    logic [2:0] go; // Random stall choice per path
    // Answer every request, sometimes at once and sometimes after stalls
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            k <= 16'h0000;
            fq_valid <= 1'b0;
            fq_buf_addr <= 32'h0000_0000;
            fq_desc_idx <= 16'h0000;
            mem_ack <= 1'b0;
            dq_ready <= 1'b0;
        end else begin
            go = 3'($urandom);
            mem_ack <= mem_req && !mem_ack && go[0];
            dq_ready <= dq_valid && !dq_ready && go[1];
            if (fq_valid && fq_req) begin
                k <= k + 16'h0001;
                fq_valid <= 1'b0;
                fq_buf_addr <= ~fq_buf_addr;
                fq_desc_idx <= ~fq_desc_idx;
            end else if (!fq_valid && fq_req && go[2]) begin
                // Contiguous 1 KiB buffers, each with its own index
                fq_valid <= 1'b1;
                fq_buf_addr <= 32'h2000_0000 + {6'h00, k, 10'h000};
                fq_desc_idx <= k + 16'h0005;
            end else if (!fq_valid) begin
                // Released lines keep moving so stale values never match
                fq_buf_addr <= ~fq_buf_addr;
                fq_desc_idx <= ~fq_desc_idx;
            end
        end
    end
endmodule : rsgd_host_model

//--- dv/rsgd_top_tb.sv
// Self-checking bench for the receive scatter/gather DMA
module rsgd_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rsgd_pkg::*;
    localparam logic [31:0] BASE = 32'h8000_1230; // Aligned descriptor base
    localparam int SM = 8; // Small buffer bytes
    localparam int LG = 12; // Large buffer bytes
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic rx_valid = 1'b0, rx_eop = 1'b0, rd_ph = 1'b0, rep = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rx_data = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, rx_bytes = 3'h4;
    logic [7:0] rx_chan = 8'h00, dq_chan;
    rsgd_policy_type rx_policy = POL_LARGE;
    logic hreadyout, rx_ready, fq_req, fq_small, fq_burst, fq_valid, mem_req;
    logic mem_ack, dq_valid, dq_burst, dq_ready, done_pulse, hresp;
    logic [31:0] hrdata, fq_buf_addr, mem_addr, mem_wdata, v, m;
    logic [15:0] fq_desc_idx, dq_desc_idx;
    logic [31:0] rq[$], fqq[$], dqq[$], mq[$]; // Expected results
    int n_errors = 0, n_compared = 0, k = 0, n;
    rsgd_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
        .rx_bytes(rx_bytes), .rx_eop(rx_eop), .rx_chan(rx_chan),
        .rx_policy(rx_policy), .fq_req(fq_req), .fq_small(fq_small),
        .fq_burst(fq_burst), .fq_valid(fq_valid), .fq_buf_addr(fq_buf_addr),
        .fq_desc_idx(fq_desc_idx), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_ack(mem_ack), .dq_valid(dq_valid),
        .dq_desc_idx(dq_desc_idx), .dq_chan(dq_chan), .dq_burst(dq_burst),
        .dq_ready(dq_ready), .done_pulse(done_pulse));
    rsgd_host_model host (.hclk(hclk), .hresetn(hresetn), .fq_req(fq_req),
        .fq_valid(fq_valid), .fq_buf_addr(fq_buf_addr),
        .fq_desc_idx(fq_desc_idx), .mem_req(mem_req), .mem_ack(mem_ack),
        .dq_valid(dq_valid), .dq_ready(dq_ready));
    // Clock of 100 ns period
    always #50 hclk = ~hclk;
    // Verdict and end of run
    task end_sim();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    // Hang cut short
    task bail();
        n_errors++;
        end_sim();
    endtask : bail
    // Compare seen against expected
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h, wanted %h", $time, seen, exp);
        end
    endtask : check
    // Oldest note, unknown when none is left
    function automatic logic [31:0] pop(ref logic [31:0] q[$]);
        if (q.size() == 0) begin
            return 32'hXXXX_XXXX;
        end
        return q.pop_front();
    endfunction : pop
    // Observers: take the oldest note whenever a result appears
    always @(posedge hclk) begin
        if (rd_ph) begin
            check(hrdata, pop(rq));
            check({31'h0, hresp}, 32'h0);
        end
        rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
        if (mem_req && mem_ack) begin
            check(mem_addr, pop(mq));
            v = pop(mq);
            m = pop(mq);
            check(mem_wdata & m, v & m);
        end
        if (fq_req && fq_valid) begin
            check({30'h0, fq_small, fq_burst}, pop(fqq));
        end
        if (dq_valid && dq_ready) begin
            v = {6'h00, done_pulse, dq_burst, dq_desc_idx, dq_chan};
            check(v, pop(dqq));
        end
    end
    // Wait for bus ready (0) or receive handshake (1), bounded
    task wt(input int which);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while ((which == 0 ? hreadyout : rx_ready) !== 1'b1 && n < 300);
        if (n >= 300) begin
            bail();
        end
    endtask : wt
    // One single-word AHB-Lite transfer after an idle cycle
    task ahb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h00000, a};
        hwrite <= w;
        wt(0);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt(0);
    endtask : ahb
    // Register read with its expected value noted
    task rd(input logic [11:0] a, input logic [31:0] e);
        rq.push_back(e);
        ahb(a, 1'b0, 32'h0);
    endtask : rd
    // Note one memory write: address, data, compared bits
    task wr(input logic [31:0] a, input logic [31:0] d, input logic [31:0] mk);
        mq.push_back(a);
        mq.push_back(d);
        mq.push_back(mk);
    endtask : wr
    // Note a descriptor: buffer, status/count/next, channel
    task desc(input logic [31:0] b, input logic [15:0] i, input logic [2:0] s,
              input int c, input logic [15:0] nx, input logic [7:0] ch);
        wr(BASE + {12'h000, i, 4'h0}, b, 32'hFFFF_FFFF);
        wr(BASE + {12'h000, i, 4'h4}, {s, 13'(c), nx}, 32'hFFFF_FFFF);
        wr(BASE + {12'h000, i, 4'h8}, {24'h0, ch}, 32'h0000_00FF);
    endtask : desc
    // Send one packet of nw words and note everything it must cause
    task pkt(input logic [7:0] ch, input rsgd_policy_type pol, input int nw);
        logic [31:0] bf, d;
        logic [15:0] ix, ix0;
        logic [2:0] st;
        int cnt, bs, i;
        @(posedge hclk);
        rx_chan <= ch;
        rx_policy <= pol;
        bs = (pol == POL_LARGE) ? LG : SM;
        fqq.push_back({30'h0, pol != POL_LARGE, 1'b1});
        bf = 32'h2000_0000 + 32'(k) * 32'h400;
        ix = 16'(k + 5);
        ix0 = ix;
        st = RSGD_BUFS_FIRST;
        cnt = 0;
        for (i = 0; i < nw; i++) begin
            if (cnt + 4 > bs) begin
                k++;
                fqq.push_back({30'h0, pol == POL_SMALL, 1'b1});
                if (rep) begin
                    dqq.push_back({6'h00, 2'b11, ix, ch});
                end
                desc(bf, ix, st, cnt, 16'(k + 5), ch);
                bf = 32'h2000_0000 + 32'(k) * 32'h400;
                ix = 16'(k + 5);
                st = RSGD_BUFS_MID;
                bs = (pol == POL_SMALL) ? SM : LG;
                cnt = 0;
            end
            d = $urandom;
            wr(bf + 32'(cnt), d, 32'hFFFF_FFFF);
            rx_data <= d;
            rx_bytes <= (i == nw - 1) ? 3'($urandom_range(1, 4)) : 3'h4;
            rx_eop <= (i == nw - 1);
            rx_valid <= 1'b1;
            wt(1);
            cnt += int'(rx_bytes);
        end
        rx_valid <= 1'b0;
        k++;
        desc(bf, ix, RSGD_BUFS_LAST, cnt, 16'h0000, ch);
        dqq.push_back({6'h00, 2'b11, rep ? ix : ix0, ch});
    endtask : pkt
    // Wait until every noted memory, free-queue and done-queue result has been seen, bounded
    task drain();
        n = 0;
        while (mq.size() + fqq.size() + dqq.size() != 0 && n < 3000) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 3000) begin
            bail();
        end
    endtask : drain
    // Main sequence
    initial begin
        void'($urandom(32'hE5C8));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rd(RSGD_OFS_LARGE, 32'h0);
        rd(RSGD_OFS_SMALL, 32'h0);
        ahb(RSGD_OFS_LARGE, 1'b1, 32'hFFFF_FFFF);
        rd(RSGD_OFS_LARGE, 32'h0000_1FFF);
        ahb(RSGD_OFS_SMALL, 1'b1, 32'hFFFF_FFFF);
        rd(RSGD_OFS_SMALL, 32'h0000_1FFF);
        ahb(RSGD_OFS_BASE_LO, 1'b1, 32'hFFFF_1238);
        rd(RSGD_OFS_BASE_LO, 32'h0000_1238);
        ahb(RSGD_OFS_BASE_HI, 1'b1, 32'hFFFF_8000);
        rd(RSGD_OFS_BASE_HI, 32'h0000_8000);
        rd(12'h7F0, 32'h0);
        ahb(RSGD_OFS_LARGE, 1'b1, 32'(LG));
        ahb(RSGD_OFS_SMALL, 1'b1, 32'(SM));
        ahb(RSGD_OFS_CTRL, 1'b1, 32'h0000_0007);
        pkt(8'h03, POL_LARGE, 1);
        pkt(8'h09, POL_SMALL, 5);
        pkt(8'hC8, POL_MIXED, 5);
        drain();
        // Report after every filled buffer as well as at packet end
        ahb(RSGD_OFS_CTRL, 1'b1, 32'h0000_0027);
        rep = 1'b1;
        pkt(8'h41, POL_SMALL, 5);
        drain();
        rd(RSGD_OFS_STAT, 32'h0000_0006);
        repeat (3) @(posedge hclk);
        end_sim();
    end
endmodule : rsgd_top_tb
